// ---- cmt_config.sv ----
// Mask-select and bit-timing configuration with an AXI4-Lite register slave and a nominal bit timer.
// Assumes can_rx is already synchronous to aclk (dominant = 0) and sleep_mode comes from the mode logic.
//
// Local design decisions: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
module cmt_config
	import cmt_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic can_rx,
	input wire logic sleep_mode,
	output cmt_mask_use_t filter_mask_use,
	output logic [3:0] phase2_quanta,
	output logic sample_point,
	output logic sampled_bit,
	output logic bit_start,
	output logic wake_event
);

	cmt_state_t s_q;
	cmt_state_t s_d;
	cmt_mask_use_t use_dec;
	logic [3:0] prop_len;
	logic [3:0] ph1_len;
	logic [3:0] ph2_len;
	logic [5:0] prescaler;
	logic quantum_tick;
	logic seg_done;
	logic majority;
	logic [31:0] rd_word;
	logic rd_hit;

	////////////////////////////////////////////////////////////////////////////
	// Selector decode, one copy per filter; filter n lives in register n/4, bits 2*(n%4)+1:2*(n%4)
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++)
		begin : g_filter
			logic [1:0] sel;
			assign sel = s_q.cfg.mask_choice[gi / 4][2 * (gi % 4) +: 2];
			assign use_dec[gi] = {sel == CMT_SEL_NONE, sel == CMT_SEL_FILTER15,
				sel == CMT_SEL_MASK1, sel == CMT_SEL_MASK0};
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Segment lengths in quanta
	assign prescaler = s_q.cfg.prescale[5:0];
	assign prop_len = {1'b0, s_q.cfg.segments[CMT_POS_PROP +: 3]} + 4'h1;
	assign ph1_len = {1'b0, s_q.cfg.segments[CMT_POS_PH1 +: 3]} + 4'h1;
	// Automatic phase 2 never shorter than processing time, so the field is ignored here
	always_comb
	begin
		if (s_q.cfg.segments[CMT_POS_PH2_PROG])
			ph2_len = {1'b0, s_q.cfg.phase2_wake[CMT_POS_PH2 +: 3]} + 4'h1;
		else
			ph2_len = (ph1_len > CMT_PROC_TIME_QUANTA) ? ph1_len : CMT_PROC_TIME_QUANTA;
	end
	assign quantum_tick = (s_q.quantum_cnt == prescaler);
	// Vote over the two earlier quantum samples and the line at the sample point itself
	assign majority = (s_q.samples[0] & s_q.samples[1]) | (s_q.samples[0] & can_rx)
		| (s_q.samples[1] & can_rx);

	////////////////////////////////////////////////////////////////////////////
	// Read mux; unused and reserved bits read as zero
	always_comb
	begin
		rd_word = 32'h0000_0000;
		rd_hit = 1'b1;
		case (s_axi_araddr[4:0])
			CMT_OFF_MASK_CHOICE_0: rd_word[7:0] = s_q.cfg.mask_choice[0];
			CMT_OFF_MASK_CHOICE_1: rd_word[7:0] = s_q.cfg.mask_choice[1];
			CMT_OFF_MASK_CHOICE_2: rd_word[7:0] = s_q.cfg.mask_choice[2];
			CMT_OFF_MASK_CHOICE_3: rd_word[7:0] = s_q.cfg.mask_choice[3];
			CMT_OFF_PRESCALE: rd_word[7:0] = s_q.cfg.prescale;
			CMT_OFF_SEGMENTS: rd_word[7:0] = s_q.cfg.segments;
			CMT_OFF_PHASE2_WAKE: rd_word[7:0] = s_q.cfg.phase2_wake & CMT_PH2_WAKE_MASK;
			CMT_OFF_CONTROL: rd_word[7:0] = {s_q.seg, 3'h0, s_q.cfg.config_mode};
			default: rd_hit = 1'b0;
		endcase
		if (s_axi_araddr[31:5] != 27'h0 || s_axi_araddr[1:0] != 2'h0)
			rd_hit = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic for bus, configuration, bit timer and wake detection
	always_comb
	begin
		s_d = s_q;
		seg_done = 1'b0;
		// Write address and data may arrive in either order
		if (s_axi_awvalid && s_q.bus.awready)
		begin
			s_d.bus.awaddr = s_axi_awaddr[4:0];
			s_d.bus.aw_got = 1'b1;
		end
		if (s_axi_wvalid && s_q.bus.wready)
		begin
			s_d.bus.wdata = s_axi_wdata;
			s_d.bus.wstrb = s_axi_wstrb;
			s_d.bus.w_got = 1'b1;
		end
		if (s_axi_bvalid && s_axi_bready)
			s_d.bus.bvalid = 1'b0;
		// Commit once both halves are held; outside configuration mode, writes other than to control answer OKAY but store nothing
		if (s_q.bus.aw_got && s_q.bus.w_got && !s_q.bus.bvalid)
		begin
			s_d.bus.aw_got = 1'b0;
			s_d.bus.w_got = 1'b0;
			s_d.bus.bvalid = 1'b1;
			s_d.bus.bresp = CMT_RESP_OKAY;
			if (s_q.bus.awaddr[1:0] != 2'h0)
				s_d.bus.bresp = CMT_RESP_SLVERR;
			else if (s_q.bus.wstrb[0])
			begin
				case (s_q.bus.awaddr)
					CMT_OFF_MASK_CHOICE_0, CMT_OFF_MASK_CHOICE_1, CMT_OFF_MASK_CHOICE_2, CMT_OFF_MASK_CHOICE_3:
						if (s_q.cfg.config_mode)
							s_d.cfg.mask_choice[s_q.bus.awaddr[3:2]] = s_q.bus.wdata[7:0];
					CMT_OFF_PRESCALE:
						if (s_q.cfg.config_mode)
							s_d.cfg.prescale = s_q.bus.wdata[7:0];
					CMT_OFF_SEGMENTS:
						if (s_q.cfg.config_mode)
							s_d.cfg.segments = s_q.bus.wdata[7:0];
					CMT_OFF_PHASE2_WAKE:
						if (s_q.cfg.config_mode)
							s_d.cfg.phase2_wake = s_q.bus.wdata[7:0] & CMT_PH2_WAKE_MASK;
					CMT_OFF_CONTROL: s_d.cfg.config_mode = s_q.bus.wdata[CMT_POS_CONFIG];
					default: s_d.bus.bresp = CMT_RESP_SLVERR;
				endcase
			end
			else if (s_q.bus.awaddr > CMT_OFF_CONTROL)
				s_d.bus.bresp = CMT_RESP_SLVERR;
		end
		// Ready stays low while a half is held or a response waits, so one write at a time
		s_d.bus.awready = !s_d.bus.aw_got && !s_d.bus.bvalid && !(s_q.bus.aw_got && s_q.bus.w_got);
		s_d.bus.wready = !s_d.bus.w_got && !s_d.bus.bvalid && !(s_q.bus.aw_got && s_q.bus.w_got);
		// Reads answer one cycle after the address is taken
		if (s_axi_rvalid && s_axi_rready)
			s_d.bus.rvalid = 1'b0;
		if (s_axi_arvalid && s_q.bus.arready)
		begin
			s_d.bus.rvalid = 1'b1;
			s_d.bus.rdata = rd_word;
			s_d.bus.rresp = rd_hit ? CMT_RESP_OKAY : CMT_RESP_SLVERR;
		end
		s_d.bus.arready = !s_d.bus.rvalid && !(s_axi_arvalid && s_q.bus.arready);

		// Bit timer; held at the start of sync while configuring so a new setting starts clean
		s_d.sample_point = 1'b0;
		s_d.bit_start = 1'b0;
		if (s_q.cfg.config_mode)
		begin
			s_d.seg = CMT_SEG_SYNC;
			s_d.quantum_cnt = 6'h00;
			s_d.q_cnt = 4'h0;
		end
		else
		begin
			s_d.quantum_cnt = quantum_tick ? 6'h00 : s_q.quantum_cnt + 6'h01;
			if (quantum_tick)
			begin
				// Keep the last three quantum samples for majority voting
				s_d.samples = {s_q.samples[1:0], can_rx};
				s_d.q_cnt = s_q.q_cnt + 4'h1;
				case (s_q.seg)
					CMT_SEG_SYNC: seg_done = 1'b1;
					CMT_SEG_PROP: seg_done = (s_q.q_cnt == prop_len - 4'h1);
					CMT_SEG_PH1: seg_done = (s_q.q_cnt == ph1_len - 4'h1);
					CMT_SEG_PH2: seg_done = (s_q.q_cnt == ph2_len - 4'h1);
					default: seg_done = 1'b1;
				endcase
				if (seg_done)
				begin
					s_d.q_cnt = 4'h0;
					case (s_q.seg)
						CMT_SEG_SYNC: s_d.seg = CMT_SEG_PROP;
						CMT_SEG_PROP: s_d.seg = CMT_SEG_PH1;
						CMT_SEG_PH1:
						begin
							s_d.seg = CMT_SEG_PH2;
							s_d.sample_point = 1'b1;
							// Voting covers the two quanta before the point and the point itself
							if (s_q.cfg.segments[CMT_POS_TRIPLE])
								s_d.sampled_bit = majority;
							else
								s_d.sampled_bit = can_rx;
						end
						default:
						begin
							s_d.seg = CMT_SEG_SYNC;
							s_d.bit_start = 1'b1;
						end
					endcase
				end
			end
		end

		// Wake detection on a dominant line while asleep; filter wants a stable dominant
		s_d.wake_event = 1'b0;
		s_d.wake_cnt = can_rx ? 4'h0 : ((s_q.wake_cnt == CMT_WAKE_FILT_CYC) ? s_q.wake_cnt : s_q.wake_cnt + 4'h1);
		if (sleep_mode && !s_q.cfg.phase2_wake[CMT_POS_WAKE_DIS] && !can_rx)
		begin
			if (!s_q.cfg.phase2_wake[CMT_POS_WAKE_FILT])
				s_d.wake_event = 1'b1;
			else if (s_q.wake_cnt == CMT_WAKE_FILT_CYC - 4'h1)
				s_d.wake_event = 1'b1;
		end

		s_d.mask_use = use_dec;
		s_d.phase2_quanta = ph2_len;
	end

	////////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_q <= '0;
			s_q.cfg.mask_choice <= {CMT_RST_MASK_CHOICE_3, CMT_RST_MASK_CHOICE_2,
				CMT_RST_MASK_CHOICE_1, CMT_RST_MASK_CHOICE_0};
			s_q.cfg.prescale <= CMT_RST_TIMING;
			s_q.cfg.segments <= CMT_RST_TIMING;
			s_q.cfg.phase2_wake <= CMT_RST_TIMING;
			s_q.cfg.config_mode <= CMT_RST_CONTROL[CMT_POS_CONFIG];
			s_q.seg <= CMT_SEG_SYNC;
			s_q.samples <= 3'h7;
			s_q.sampled_bit <= 1'b1;
			s_q.phase2_quanta <= CMT_PROC_TIME_QUANTA;
		end
		else
			s_q <= s_d;
	end

	// Outputs straight from the state register
	assign s_axi_awready = s_q.bus.awready;
	assign s_axi_wready = s_q.bus.wready;
	assign s_axi_bvalid = s_q.bus.bvalid;
	assign s_axi_bresp = s_q.bus.bresp;
	assign s_axi_arready = s_q.bus.arready;
	assign s_axi_rvalid = s_q.bus.rvalid;
	assign s_axi_rdata = s_q.bus.rdata;
	assign s_axi_rresp = s_q.bus.rresp;
	assign filter_mask_use = s_q.mask_use;
	assign phase2_quanta = s_q.phase2_quanta;
	assign sample_point = s_q.sample_point;
	assign sampled_bit = s_q.sampled_bit;
	assign bit_start = s_q.bit_start;
	assign wake_event = s_q.wake_event;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	logic commit;
	assign commit = s_q.bus.aw_got && s_q.bus.w_got && !s_q.bus.bvalid;

	sequence seq_ph1_end;
		s_q.seg == CMT_SEG_PH1 && quantum_tick && s_q.q_cnt == ph1_len - 4'h1 && !s_q.cfg.config_mode;
	endsequence

	sequence seq_ph2_end;
		s_q.seg == CMT_SEG_PH2 && quantum_tick && s_q.q_cnt == ph2_len - 4'h1 && !s_q.cfg.config_mode;
	endsequence

	a_mask_choice_guard: assert property (commit && !s_q.cfg.config_mode |=> $stable(s_q.cfg.mask_choice))
		else $error("mask choice changed outside configuration mode");
	a_timing_guard: assert property (commit && !s_q.cfg.config_mode
		|=> $stable({s_q.cfg.prescale, s_q.cfg.segments, s_q.cfg.phase2_wake}))
		else $error("timing register changed outside configuration mode");
	a_mask_decode: assert property (aresetn |=> filter_mask_use[5][$past(s_q.cfg.mask_choice[1][3:2])]
		&& $countones(filter_mask_use[5]) == 1)
		else $error("filter 5 mask use does not match its selector");
	a_phase2_length: assert property (!s_q.cfg.config_mode |-> phase2_quanta == $past(ph2_len)
		&& (s_q.cfg.segments[CMT_POS_PH2_PROG] || ph2_len >= CMT_PROC_TIME_QUANTA))
		else $error("phase 2 length wrong");
	a_sample_at_ph1_end: assert property (seq_ph1_end |=> sample_point && s_q.seg == CMT_SEG_PH2)
		else $error("sample point not at end of phase 1");
	a_ph2_to_sync: assert property (seq_ph2_end |=> bit_start && s_q.seg == CMT_SEG_SYNC ##1 !bit_start)
		else $error("bit did not restart after phase 2");
	a_triple_vote: assert property (seq_ph1_end and (s_q.cfg.segments[CMT_POS_TRIPLE] && !s_q.samples[0]
		&& !s_q.samples[1]) |=> !sampled_bit)
		else $error("majority vote ignored");
	a_wake_disable: assert property (s_q.cfg.phase2_wake[CMT_POS_WAKE_DIS] |=> !wake_event)
		else $error("wake event while wake-up disabled");
	a_wake_filter: assert property (sleep_mode && !can_rx && !s_q.cfg.phase2_wake[CMT_POS_WAKE_DIS]
		&& !s_q.cfg.phase2_wake[CMT_POS_WAKE_FILT] |=> wake_event)
		else $error("unfiltered wake missed");
	a_reserved_zero: assert property (s_axi_arvalid && s_q.bus.arready && s_axi_araddr == {27'h0, CMT_OFF_PHASE2_WAKE}
		|=> s_axi_rvalid && s_axi_rdata[5:3] == 3'h0)
		else $error("reserved timing bits read nonzero");
	a_prescale_tick: assert property (!s_q.cfg.config_mode && s_q.quantum_cnt == prescaler |=> s_q.quantum_cnt == 6'h00
		|| s_q.cfg.config_mode)
		else $error("quantum counter overran prescaler");
	a_prop_length: assert property (s_q.seg == CMT_SEG_PROP && quantum_tick && !s_q.cfg.config_mode
		&& s_q.q_cnt == prop_len - 4'h1 |=> s_q.seg == CMT_SEG_PH1)
		else $error("propagation segment length wrong");

	// Sync is a single quantum, and a configuring controller keeps the timer parked there
	a_sync_length: assert property (s_q.seg == CMT_SEG_SYNC && quantum_tick && !s_q.cfg.config_mode
		|=> s_q.seg == CMT_SEG_PROP)
		else $error("sync segment longer than one quantum");
	a_config_park: assert property (s_q.cfg.config_mode
		|=> s_q.seg == CMT_SEG_SYNC && !sample_point && !bit_start)
		else $error("bit timer ran while configuring");
	a_single_sample: assert property (seq_ph1_end and !s_q.cfg.segments[CMT_POS_TRIPLE]
		|=> sampled_bit == $past(can_rx))
		else $error("single sample not taken at the sample point");

	// Phase 2 length against the fields one cycle earlier; a phase 1 of two or more quanta
	// is never shorter than the two-quantum processing time, so it wins the maximum
	a_ph2_programmed: assert property (s_q.cfg.segments[CMT_POS_PH2_PROG]
		|=> phase2_quanta == {1'b0, $past(s_q.cfg.phase2_wake[CMT_POS_PH2 +: 3])} + 4'h1)
		else $error("programmed phase 2 length wrong");
	a_ph2_follows_ph1: assert property (!s_q.cfg.segments[CMT_POS_PH2_PROG]
		&& s_q.cfg.segments[CMT_POS_PH1 +: 3] != 3'h0
		|=> phase2_quanta == {1'b0, $past(s_q.cfg.segments[CMT_POS_PH1 +: 3])} + 4'h1)
		else $error("automatic phase 2 differs from phase 1");
	a_ph2_proc_time: assert property (!s_q.cfg.segments[CMT_POS_PH2_PROG]
		&& s_q.cfg.segments[CMT_POS_PH1 +: 3] == 3'h0 |=> phase2_quanta == CMT_PROC_TIME_QUANTA)
		else $error("automatic phase 2 shorter than processing time");

	// Decoded use lags the selector by one cycle; reset clears the decoded copy first
	a_no_mask_decode: assert property (s_q.cfg.mask_choice[0][7:6] == CMT_SEL_NONE
		|=> filter_mask_use[3] == 4'h8)
		else $error("filter 3 not decoded as no mask");
	a_filter15_decode: assert property (s_q.cfg.mask_choice[3][7:6] == CMT_SEL_FILTER15
		|=> filter_mask_use[15] == 4'h4)
		else $error("filter 15 not decoded as filter 15 mask");
	a_mask1_decode: assert property (aresetn && s_q.cfg.mask_choice[1][1:0] == CMT_SEL_MASK1
		|=> filter_mask_use[4] == 4'h2)
		else $error("filter 4 not decoded as mask 1");
endmodule

// ---- cmt_pkg.sv ----
// Constants, register map and state carriers for the CAN mask-select and bit-timing block.
// Assumes a single 10 MHz clock, synchronous active-low reset and an AXI4-Lite master.
//
// How it works
// - Each filter's 2-bit selector picks mask 0, mask 1, filter 15, or no mask.
// - Four selectors per byte register, lowest filter in bits 1-0, four registers.
// - Selector registers change only while configuration mode is set.
// - All three timing registers change only while configuration mode is set.
// - Phase 2 uses its field when programmable, else max of phase 1 and processing time.
// - Triple-sample takes a majority of three samples, otherwise one sample at the point.
// - Phase 1 lasts field plus one quanta, field in bits 5-3 of segments register.
// - Propagation lasts field plus one quanta, field in bits 2-0 of segments register.
// - Programmable phase 2 lasts field plus one quanta, bits 2-0 of third register.
// - Phase 2 length field is ignored while phase-2 programmable bit is clear.
// - Wake-disable set blocks bus-activity wake-up; clear lets activity wake the device.
// - Wake line-filter set filters the bus line before wake detection.
// - Bits 5-3 of the third timing register read as zero.
package cmt_pkg;
	// Register byte offsets
	localparam logic [4:0] CMT_OFF_MASK_CHOICE_0 = 5'h00;
	localparam logic [4:0] CMT_OFF_MASK_CHOICE_1 = 5'h04;
	localparam logic [4:0] CMT_OFF_MASK_CHOICE_2 = 5'h08;
	localparam logic [4:0] CMT_OFF_MASK_CHOICE_3 = 5'h0C;
	localparam logic [4:0] CMT_OFF_PRESCALE = 5'h10;
	localparam logic [4:0] CMT_OFF_SEGMENTS = 5'h14;
	localparam logic [4:0] CMT_OFF_PHASE2_WAKE = 5'h18;
	localparam logic [4:0] CMT_OFF_CONTROL = 5'h1C;
	// Reset values
	localparam logic [7:0] CMT_RST_MASK_CHOICE_0 = 8'h50;
	localparam logic [7:0] CMT_RST_MASK_CHOICE_1 = 8'h05;
	localparam logic [7:0] CMT_RST_MASK_CHOICE_2 = 8'h00;
	localparam logic [7:0] CMT_RST_MASK_CHOICE_3 = 8'h00;
	localparam logic [7:0] CMT_RST_TIMING = 8'h00;
	localparam logic [7:0] CMT_RST_CONTROL = 8'h01;
	// Field positions
	localparam int CMT_POS_JUMP_WIDTH = 6;
	localparam int CMT_POS_PH2_PROG = 7;
	localparam int CMT_POS_TRIPLE = 6;
	localparam int CMT_POS_PH1 = 3;
	localparam int CMT_POS_PROP = 0;
	localparam int CMT_POS_WAKE_DIS = 7;
	localparam int CMT_POS_WAKE_FILT = 6;
	localparam int CMT_POS_PH2 = 0;
	localparam int CMT_POS_CONFIG = 0;
	localparam logic [7:0] CMT_PH2_WAKE_MASK = 8'hC7;
	// Selector encodings
	localparam logic [1:0] CMT_SEL_MASK0 = 2'h0;
	localparam logic [1:0] CMT_SEL_MASK1 = 2'h1;
	localparam logic [1:0] CMT_SEL_FILTER15 = 2'h2;
	localparam logic [1:0] CMT_SEL_NONE = 2'h3;
	// Timing: processing time in quanta, wake line filter time
	localparam logic [3:0] CMT_PROC_TIME_QUANTA = 4'h2;
	localparam int CMT_WAKE_FILT_NS = 500;
	localparam int CMT_CLK_NS = 100;
	localparam logic [3:0] CMT_WAKE_FILT_CYC = 4'((CMT_WAKE_FILT_NS + CMT_CLK_NS - 1) / CMT_CLK_NS);
	localparam logic [1:0] CMT_RESP_OKAY = 2'h0;
	localparam logic [1:0] CMT_RESP_SLVERR = 2'h2;

	// One-hot mask use per filter: {none, filter15, mask1, mask0}
	typedef logic [15:0][3:0] cmt_mask_use_t;

	typedef enum logic [3:0] {
		CMT_SEG_SYNC = 4'h1,
		CMT_SEG_PROP = 4'h2,
		CMT_SEG_PH1 = 4'h4,
		CMT_SEG_PH2 = 4'h8
	} cmt_seg_t;

	typedef struct packed {
		logic [4:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic aw_got;
		logic w_got;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} cmt_bus_t;

	typedef struct packed {
		logic [3:0][7:0] mask_choice;
		logic [7:0] prescale;
		logic [7:0] segments;
		logic [7:0] phase2_wake;
		logic config_mode;
	} cmt_cfg_t;

	typedef struct packed {
		cmt_bus_t bus;
		cmt_cfg_t cfg;
		cmt_seg_t seg;
		logic [5:0] quantum_cnt;
		logic [3:0] q_cnt;
		logic [2:0] samples;
		logic [3:0] wake_cnt;
		cmt_mask_use_t mask_use;
		logic [3:0] phase2_quanta;
		logic sample_point;
		logic sampled_bit;
		logic bit_start;
		logic wake_event;
	} cmt_state_t;
endpackage

// ---- cmt_bus_node.sv ----
// Far-side bus node model: the other nodes on the shared bus, seen as one receive line.
// Assumes the bench asks for a dominant level through tx_dom; a released bus floats recessive.
`timescale 1ns/1ps
module cmt_bus_node
	import cmt_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic tx_dom,
	output logic can_rx
);
	// Registered line; the bus pull-up makes an idle line recessive, never the last driven value
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			can_rx <= 1'b1;
		else
			can_rx <= ~tx_dom;
	end
endmodule

// ---- tb_can_mask_select_bit_timing.sv ----
// Self-checking bench: register access, selector decode, write lock-out, bit timer, wake-up.
// Assumes cmt_config behind an AXI4-Lite master and the bus node model on its receive line.
`timescale 1ns/1ps
module tb_can_mask_select_bit_timing
	import cmt_pkg::*;
;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0, sleep = 1'b0, tx_dom = 1'b0;
	logic [31:0] awa = '0, wd = '0, ara = '0, rdat;
	logic awr, wr_rdy, bv, arr, rv, can_rx, sp, sb, bs, wake;
	logic [1:0] bresp, rresp;
	logic [3:0] ph2q;
	cmt_mask_use_t mask_use;
	int checks = 0;
	int n_mismatch = 0;

	////////////////////////////////////////////////////////////////////////////////
	// Clock and instances
	initial
	begin
		forever #50 aclk = ~aclk;
	end

	cmt_config u_cmt_config (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy),
		.s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
		.can_rx(can_rx), .sleep_mode(sleep), .filter_mask_use(mask_use), .phase2_quanta(ph2q),
		.sample_point(sp), .sampled_bit(sb), .bit_start(bs), .wake_event(wake));

	cmt_bus_node u_cmt_bus_node (.aclk(aclk), .aresetn(aresetn), .tx_dom(tx_dom), .can_rx(can_rx));

	////////////////////////////////////////////////////////////////////////////////
	// Shared tasks; each bus task is entered just after a rising edge
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic [1:0] er);
		awa <= {26'h0, a};
		wd <= {24'h0, d};
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awr)
				awv <= 1'b0;
			if (wr_rdy)
				wv <= 1'b0;
		end
		while (!bv);
		br <= 1'b0;
		check({30'h0, bresp}, {30'h0, er}, "write resp");
		@(posedge aclk); // Gap so no valid is lowered and raised in one step
	endtask

	task automatic rd(input logic [5:0] a, input logic [7:0] exp, input logic [1:0] er);
		ara <= {26'h0, a};
		arv <= 1'b1;
		rr <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arr)
				arv <= 1'b0;
		end
		while (!rv);
		rr <= 1'b0;
		check(rdat, {24'h0, exp}, "read data");
		check({30'h0, rresp}, {30'h0, er}, "read resp");
		@(posedge aclk);
	endtask

	// Decoded use follows the selector one cycle late, so let two edges pass first
	task automatic masks(input logic [3:0][7:0] p);
		repeat (2) @(posedge aclk);
		for (int f = 0; f < 16; f++)
			check({28'h0, mask_use[f]}, {28'h0, 4'h1 << p[f / 4][2 * (f % 4)+:2]}, "mask use");
	endtask

	// Bounded waits: a broken timer ends the loop instead of hanging the bench
	task automatic meas(output int gap, output int per);
		int n;
		n = 0;
		while (!sp && n < 100)
		begin
			@(posedge aclk);
			n++;
		end
		gap = 0;
		do
		begin
			@(posedge aclk);
			gap++;
		end
		while (!bs && gap < 100);
		per = 0;
		do
		begin
			@(posedge aclk);
			per++;
		end
		while (!bs && per < 100);
	endtask

	// Wake pulses are counted while the line is dominant and for a while after
	task automatic wk(input logic [7:0] cfg, input int len, input logic exp);
		int hits;
		hits = 0;
		wr(6'h18, cfg, 2'h0);
		for (int i = 0; i < len + 12; i++)
		begin
			tx_dom <= (i < len);
			@(posedge aclk);
			if (wake === 1'b1)
				hits++;
		end
		check({31'h0, hits != 0}, {31'h0, exp}, "wake");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset();
		for (int r = 0; r < 7; r++)
			rd(6'(4 * r), (r == 0) ? 8'h50 : (r == 1) ? 8'h05 : 8'h00, 2'h0);
		// Only address bits 4:0 pick a register, so the refused 0x20 read still carries choice 0
		rd(6'h20, CMT_RST_MASK_CHOICE_0, 2'h2);
		rd(6'h02, 8'h00, 2'h2);
		wr(6'h01, 8'h55, 2'h2);
		masks(32'h0000_0550);
		$display("test reset done");
	endtask

	task automatic t_decode();
		logic [3:0][7:0] p;
		p = {8'hB1, 8'h4E, 8'h1B, 8'hE4};
		for (int r = 0; r < 4; r++)
		begin
			wr(6'(4 * r), p[r], 2'h0);
			rd(6'(4 * r), p[r], 2'h0);
		end
		masks(p);
		wr(6'h10, 8'hC5, 2'h0);
		rd(6'h10, 8'hC5, 2'h0);
		wr(6'h14, 8'hA5, 2'h0);
		rd(6'h14, 8'hA5, 2'h0);
		wr(6'h18, 8'hFF, 2'h0);
		rd(6'h18, 8'hC7, 2'h0);
		$display("test decode done");
	endtask

	// Outside configuration mode every write to registers 0x00-0x18 is answered but must store nothing; control still stores
	task automatic t_lock();
		logic [6:0][7:0] old;
		old = {8'hC7, 8'hA5, 8'hC5, 8'hB1, 8'h4E, 8'h1B, 8'hE4};
		wr(6'h1C, 8'h00, 2'h0);
		for (int r = 0; r < 7; r++)
		begin
			wr(6'(4 * r), ~old[r], 2'h0);
			rd(6'(4 * r), old[r], 2'h0);
		end
		wr(6'h1C, 8'h01, 2'h0);
		$display("test lock done");
	endtask

	// Prescaler 1 gives two clocks a quantum; cases cover auto, programmable and processing-time phase 2
	task automatic t_timer();
		logic [7:0] segs[3] = '{8'h11, 8'hD1, 8'h01};
		logic [7:0] ph2r[3] = '{8'h07, 8'h07, 8'h05};
		logic [3:0] q[3] = '{4'h3, 4'h8, 4'h2};
		int gaps[3] = '{6, 16, 4};
		int pers[3] = '{18, 28, 12};
		int gap, per;
		wr(6'h10, 8'h01, 2'h0);
		for (int c = 0; c < 3; c++)
		begin
			tx_dom <= (c == 1);
			wr(6'h14, segs[c], 2'h0);
			wr(6'h18, ph2r[c], 2'h0);
			wr(6'h1C, 8'h00, 2'h0);
			meas(gap, per);
			check({28'h0, ph2q}, {28'h0, q[c]}, "phase 2 quanta");
			check(32'(gap), 32'(gaps[c]), "phase 2 span");
			check(32'(per), 32'(pers[c]), "bit period");
			check({31'h0, sb}, {31'h0, c != 1}, "sampled bit");
			wr(6'h1C, 8'h01, 2'h0);
		end
		tx_dom <= 1'b0;
		$display("test timer done");
	endtask

	task automatic t_wake();
		sleep <= 1'b1;
		wk(8'h00, 3, 1'b1);
		wk(8'h80, 8, 1'b0);
		wk(8'h40, 2, 1'b0);
		wk(8'h40, 8, 1'b1);
		sleep <= 1'b0;
		$display("test wake done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Closing, main sequence and watchdog
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial
	begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset();
		t_decode();
		t_lock();
		t_timer();
		t_wake();
		stop_test();
	end

	// The whole run needs well under a thousand clocks
	initial
	begin
		#(4000 * 100);
		n_mismatch++;
		stop_test();
	end
endmodule
